// ---- dsoc_top.sv ----
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
// distance processing, switching outputs and interface selection
module dsoc_top
  import dsoc_pkg::*;
#(
  parameter int          W         = 32,
  parameter int          RANGE_MM  = 300000
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  // register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // raw measurement in mm
  input  wire logic [W-1:0]  raw_dist,
  input  wire logic          raw_valid,
  // adapter link and serial request
  input  wire logic          adapter_link_up,
  input  wire logic          adapter_connected,
  input  wire logic          host_request,
  // outputs
  output logic               first_switch_output,
  output logic               second_switch_output,
  output logic      [W-1:0]  out_value,
  output logic      [24:0]   ssi_word,
  output logic               serial_send,
  output logic               searching,
  output logic      [1:0]    if_sel,
  output logic      [5:0]    serial_cfg,
  output logic      [6:0]    bus_addr
);
  logic                rst_q1;
  logic                rst_n;
  logic [31:0]         ctrl;
  logic [7:0]          hyst;
  logic signed [W-1:0] offset_mm;
  logic signed [W-1:0] dist_mm;
  logic signed [W-1:0] corr_mm;
  logic signed [W-1:0] corr_unit;
  logic signed [W+7:0] inch_prod;
  logic                is_ssi;
  logic                teach1;
  logic                teach2;
  logic signed [W-1:0] sp1;
  logic signed [W-1:0] sp2;
  logic [W+3:0]        ssi_scaled;
  logic [24:0]         ssi_bin;
  logic                search_lost;
  logic                wr_cmd;
  logic signed [W-1:0] wdata_s;
  logic signed [W-1:0] range_unit;
  logic                wr_ctrl;
  logic                wr_hyst;
  logic                wr_ofs;
  logic                wr_addr;
  logic                wr_ser;
  logic                hyst_ok;
  logic                addr_ok;
  logic                baud_ok;
  logic                ofs_ok;
  logic                cmd_teach_ofs;
  logic                cmd_clr_ofs;
  logic                cmd_cancel;
  logic                cmd_send;
  logic [1:0]          sw_window;
  logic [1:0]          sw_invert;
  logic [1:0]          sw_teach;
  logic [1:0]          sw_out;
  logic signed [W-1:0] sw_ref [2];
  logic [24:0]         ssi_gray;
  logic                next_send;
  logic [31:0]         next_rdata;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  assign wr_cmd  = reg_wr && (reg_addr == OFS_CMD);
  assign wdata_s = W'(signed'(reg_wdata));
  assign if_sel  = ctrl[CTRL_IFSEL +: 2];
  assign is_ssi  = (if_sel == DSOC_IF_SSI10) || (if_sel == DSOC_IF_SSI8);

  // write strobes per register
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_hyst = reg_wr && (reg_addr == OFS_HYST);
  assign wr_ofs  = reg_wr && (reg_addr == OFS_OFFSET);
  assign wr_addr = reg_wr && (reg_addr == OFS_ADDR);
  assign wr_ser  = reg_wr && (reg_addr == OFS_SERIAL);

  // illegal values are dropped silently, the old setting stays
  assign hyst_ok = (reg_wdata[7:0] <= HYST_MAX);
  assign addr_ok = (reg_wdata[31:7] == 25'h0)
                   && (reg_wdata[6:0] >= ADDR_MIN) && (reg_wdata[6:0] <= ADDR_MAX);
  assign baud_ok = (reg_wdata[SER_BAUD +: 3] <= 3'h4);
  assign ofs_ok  = (wdata_s <= W'(OFFSET_MAX)) && (wdata_s >= -W'(OFFSET_MAX));

  // command bits, only meaningful with a command write
  assign cmd_teach_ofs = wr_cmd && reg_wdata[CMD_TEACHOF];
  assign cmd_clr_ofs   = wr_cmd && reg_wdata[CMD_CLROF];
  assign cmd_cancel    = wr_cmd && reg_wdata[CMD_CANCEL];
  assign cmd_send      = wr_cmd && reg_wdata[CMD_SEND];

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= {23'h0, reg_wdata[8:0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hyst <= RST_HYST;
    end else if (wr_hyst && hyst_ok) begin
      hyst <= reg_wdata[7:0];
    end
  end

  // out-of-range addresses are ignored, old value kept
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_addr <= RST_ADDR;
    end else if (wr_addr && addr_ok) begin
      bus_addr <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_cfg <= RST_SERIAL;
    end else if (wr_ser && baud_ok) begin
      serial_cfg <= reg_wdata[5:0];
    end
  end

  // offset kept in mm; the written value is taken in mm too
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      offset_mm <= RST_OFFSET[W-1:0];
    end else if (cmd_clr_ofs) begin
      offset_mm <= '0;
    end else if (cmd_teach_ofs) begin
      offset_mm <= -dist_mm;
    end else if (wr_ofs && ofs_ok) begin
      offset_mm <= wdata_s;
    end
  end

  // latest raw reading
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dist_mm <= '0;
    end else if (raw_valid) begin
      dist_mm <= raw_dist;
    end
  end

  assign corr_mm   = dist_mm + offset_mm;
  // hundredths of an inch: mm * 100 / 25.4 = mm * 1000 / 254
  assign inch_prod = (W+8)'(corr_mm) * 1000 / 254;
  assign corr_unit = ctrl[CTRL_UNIT] ? inch_prod[W-1:0] : corr_mm;
  assign range_unit = ctrl[CTRL_UNIT] ? W'(RANGE_MM * 100 / 254 * 10) : W'(RANGE_MM);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_value <= '0;
    end else begin
      out_value <= corr_unit;
    end
  end

  // switch point teach commands blocked while SSI is selected; the offset teach is not
  assign teach1 = wr_cmd && reg_wdata[CMD_TEACH1] && !is_ssi;
  assign teach2 = wr_cmd && reg_wdata[CMD_TEACH2] && !is_ssi;

  assign sw_window = {ctrl[CTRL_MODE2], ctrl[CTRL_MODE1]};
  assign sw_invert = {ctrl[CTRL_POL2], ctrl[CTRL_POL1]};
  assign sw_teach  = {teach2, teach1};

  // hysteresis counts in the active unit's counts
  for (genvar i = 0; i < 2; i++) begin : g_sw
    dsoc_switch #(
      .W (W)
    ) u_sw (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .window_mode (sw_window[i]),
      .invert      (sw_invert[i]),
      .hyst        (hyst),
      .range_end   (range_unit),
      .value       (corr_unit),
      .teach       (sw_teach[i]),
      .ref_point   (sw_ref[i]),
      .out_on      (sw_out[i])
    );
  end

  assign sp1                  = sw_ref[0];
  assign sp2                  = sw_ref[1];
  assign first_switch_output  = sw_out[0];
  assign second_switch_output = sw_out[1];

  // SSI position: counts of 0.1 mm = mm*10, of 0.125 mm = mm*8
  always_comb begin
    if (corr_mm < 0) begin
      ssi_scaled = '0;
    end else if (if_sel == DSOC_IF_SSI8) begin
      ssi_scaled = (W+4)'(corr_mm) << 3;
    end else begin
      ssi_scaled = (W+4)'(corr_mm) * 10;
    end
  end

  // 24 bit codes keep the top bit at zero
  assign ssi_bin = ctrl[CTRL_CODE] ? ssi_scaled[24:0] : {1'b0, ssi_scaled[23:0]};

  // reflected code: neighbouring positions differ in one bit only
  assign ssi_gray = ssi_bin ^ (ssi_bin >> 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ssi_word <= '0;
    end else if (ctrl[CTRL_CODE + 1]) begin
      ssi_word <= ssi_gray;
    end else begin
      ssi_word <= ssi_bin;
    end
  end

  // send pulse: each new reading, or once per host request or send command
  always_comb begin
    next_send = 1'b0;
    if (if_sel == DSOC_IF_SERIAL) begin
      if (serial_cfg[SER_SINGLE]) begin
        next_send = host_request || cmd_send;
      end else begin
        next_send = raw_valid;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_send <= 1'b0;
    end else begin
      serial_send <= next_send;
    end
  end

  // searching status; a cancel stops it, restart needs a control write with the adapter connected
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      search_lost <= 1'b0;
    end else if (cmd_cancel && searching) begin
      search_lost <= 1'b1;
    end else if (search_lost && !adapter_connected) begin
      search_lost <= 1'b1;
    end else if (wr_ctrl) begin
      search_lost <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      searching <= 1'b0;
    end else begin
      searching <= (if_sel == DSOC_IF_EXTBUS) && !adapter_link_up && !search_lost;
    end
  end

  // read port, data in the cycle after the strobe
  always_comb begin
    next_rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:   next_rdata = ctrl;
        OFS_HYST:   next_rdata = {24'h0, hyst};
        OFS_OFFSET: next_rdata = 32'(offset_mm);
        OFS_ADDR:   next_rdata = {25'h0, bus_addr};
        OFS_STATUS: next_rdata = {27'h0, search_lost, searching, is_ssi,
                                  second_switch_output, first_switch_output};
        OFS_SP1:    next_rdata = 32'(sp1);
        OFS_SP2:    next_rdata = 32'(sp2);
        OFS_VALUE:  next_rdata = 32'(out_value);
        OFS_SERIAL: next_rdata = {26'h0, serial_cfg};
        default:    next_rdata = 32'h0;
      endcase
    end
  end

  // zero outside the read slot, so a stale word never looks like data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// ---- dsoc_pkg.sv ----
// shared constants for the distance output configuration block
package dsoc_pkg;
  // register offsets
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_HYST     = 4'h1;
  localparam logic [3:0] OFS_OFFSET   = 4'h2;
  localparam logic [3:0] OFS_ADDR     = 4'h3;
  localparam logic [3:0] OFS_CMD      = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h5;
  localparam logic [3:0] OFS_SP1      = 4'h6;
  localparam logic [3:0] OFS_SP2      = 4'h7;
  localparam logic [3:0] OFS_VALUE    = 4'h8;
  localparam logic [3:0] OFS_SERIAL   = 4'h9;
  // control register fields
  localparam int CTRL_UNIT   = 0;
  localparam int CTRL_IFSEL  = 1;
  localparam int CTRL_MODE1  = 3;
  localparam int CTRL_POL1   = 4;
  localparam int CTRL_MODE2  = 5;
  localparam int CTRL_POL2   = 6;
  localparam int CTRL_CODE   = 7;
  // serial register fields
  localparam int SER_BAUD    = 0;
  localparam int SER_DATA7   = 3;
  localparam int SER_STOP2   = 4;
  localparam int SER_SINGLE  = 5;
  // command register bits
  localparam int CMD_TEACH1  = 0;
  localparam int CMD_TEACH2  = 1;
  localparam int CMD_TEACHOF = 2;
  localparam int CMD_CLROF   = 3;
  localparam int CMD_CANCEL  = 4;
  localparam int CMD_SEND    = 5;
  // reset values
  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [7:0]  RST_HYST   = 8'h05;
  localparam logic [31:0] RST_OFFSET = 32'h0000_0000;
  localparam logic [6:0]  RST_ADDR   = 7'h03;
  localparam logic [2:0]  RST_BAUD   = 3'h3;
  localparam logic [5:0]  RST_SERIAL = 6'h03;
  // limits
  localparam logic [7:0]  HYST_MAX   = 8'hFE;
  localparam logic [6:0]  ADDR_MIN   = 7'h03;
  localparam logic [6:0]  ADDR_MAX   = 7'h7C;
  localparam int          OFFSET_MAX = 100000;
  localparam int          WIN_HALF   = 100;
  // interface selector codes
  typedef enum logic [1:0] {
    DSOC_IF_SERIAL  = 2'b00,
    DSOC_IF_SSI10   = 2'b01,
    DSOC_IF_SSI8    = 2'b10,
    DSOC_IF_EXTBUS  = 2'b11
  } dsoc_if_e;
  // position word codings
  typedef enum logic [1:0] {
    DSOC_PLAIN_CODE_24BIT     = 2'b00,
    DSOC_PLAIN_CODE_25BIT     = 2'b01,
    DSOC_REFLECTED_CODE_24BIT = 2'b10,
    DSOC_REFLECTED_CODE_25BIT = 2'b11
  } dsoc_code_e;
endpackage

// ---- dsoc_switch.sv ----
`timescale 1ns/100ps
// one switching output with single or window mode and hysteresis
module dsoc_switch
  import dsoc_pkg::*;
#(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // configuration
  input  wire logic                window_mode,
  input  wire logic                invert,
  input  wire logic [7:0]          hyst,
  input  wire logic signed [W-1:0] range_end,
  // value and teach
  input  wire logic signed [W-1:0] value,
  input  wire logic                teach,
  // result
  output logic signed [W-1:0]      ref_point,
  output logic                     out_on
);
  logic signed [W-1:0] half_lo;
  logic signed [W-1:0] half_hi;
  logic signed [W-1:0] lo_pt;
  logic signed [W-1:0] hi_pt;
  logic signed [W-1:0] lo_on;
  logic signed [W-1:0] lo_off;
  logic signed [W-1:0] hi_on;
  logic signed [W-1:0] hi_off;
  logic                raw;
  logic                next_raw;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_point <= '0;
    end else if (teach) begin
      ref_point <= value;
    end
  end

  // odd hysteresis rounds the upper half up
  assign half_lo = W'(hyst >> 1);
  assign half_hi = W'(hyst) - half_lo;
  assign lo_pt   = window_mode ? ref_point - W'(WIN_HALF) : ref_point;
  assign hi_pt   = ref_point + W'(WIN_HALF);
  assign lo_on   = lo_pt + half_hi;
  assign lo_off  = lo_pt - half_lo;
  assign hi_off  = (hi_pt + half_hi > range_end) ? range_end : hi_pt + half_hi;
  assign hi_on   = hi_pt - half_lo;

  // raw is "target beyond point" for single, "inside window" for double
  always_comb begin
    next_raw = raw;
    if (!window_mode) begin
      if (value >= lo_on) begin
        next_raw = 1'b1;
      end else if (value < lo_off) begin
        next_raw = 1'b0;
      end
    end else begin
      if (value >= lo_on && value <= hi_on) begin
        next_raw = 1'b1;
      end else if (value < lo_off || value > hi_off) begin
        next_raw = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      raw <= 1'b0;
    end else begin
      raw <= next_raw;
    end
  end

  assign out_on = raw ^ invert;
endmodule

// ---- dsoc_props.sv ----
// assertion checker for the distance output block
`timescale 1ns/100ps
module dsoc_props
  import dsoc_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // link side
  input wire logic        raw_valid,
  input wire logic        adapter_link_up,
  input wire logic        host_request,
  input wire logic        serial_send,
  input wire logic        searching,
  input wire logic [1:0]  if_sel,
  input wire logic [5:0]  serial_cfg,
  input wire logic [6:0]  bus_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic cmd_wr = reg_wr && reg_addr == OFS_CMD;
  wire logic ctrl_wr = reg_wr && reg_addr == OFS_CTRL;
  wire logic addr_wr = reg_wr && reg_addr == OFS_ADDR;
  wire logic cancel_wr = cmd_wr && reg_wdata[CMD_CANCEL];
  sequence cont_s;
    raw_valid && if_sel == 2'h0 && !serial_cfg[5] ##1 if_sel == 2'h0;
  endsequence
  sequence req_s;
    host_request && if_sel == 2'h0 && serial_cfg[5] ##1 if_sel == 2'h0 && serial_cfg[5];
  endsequence
  sequence idle_s;
    serial_cfg[5] && !host_request && !(cmd_wr && reg_wdata[5]) ##1 serial_cfg[5];
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  if_pick_a: assert property (ctrl_wr |=> if_sel == $past(reg_wdata[2:1]))
    else $error("interface selector did not follow write");
  cont_send_a: assert property (cont_s |-> serial_send)
    else $error("continuous mode missed a string");
  req_send_a: assert property (req_s |-> serial_send)
    else $error("request not answered");
  no_unreq_a: assert property (idle_s |-> !serial_send)
    else $error("string sent without request");
  addr_range_a: assert property (bus_addr >= ADDR_MIN && bus_addr <= ADDR_MAX)
    else $error("adapter address out of range");
  addr_keep_a: assert property (addr_wr && reg_wdata < 32'h3 |=> $stable(bus_addr))
    else $error("reserved address accepted");
  search_clr_a: assert property (if_sel != 2'h3 || adapter_link_up |=> !searching)
    else $error("searching while linked or not selected");
  search_hold_a: assert property (searching && if_sel == 2'h3 && !adapter_link_up
    && !cancel_wr && !$past(cancel_wr) |=> searching)
    else $error("search dropped without cancel");
endmodule

bind dsoc_top dsoc_props u_props (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
  .adapter_link_up(adapter_link_up), .host_request(host_request),
  .serial_send(serial_send), .searching(searching), .if_sel(if_sel),
  .serial_cfg(serial_cfg), .bus_addr(bus_addr)
);

// ---- dsoc_host.sv ----
// host controller model: asks for strings and counts them
`timescale 1ns/100ps
module dsoc_host (
  // clock
  input  wire logic clk_sys,
  // bench command and block link
  input  wire logic ask,
  input  wire logic serial_send,
  output logic      host_request,
  output int        rx_cnt
);
  // one request pulse per reading wanted
  always_ff @(posedge clk_sys) begin
    host_request <= ask;
  end
  always_ff @(posedge clk_sys) begin
    if (serial_send) begin
      rx_cnt <= rx_cnt + 1;
    end
  end
endmodule

// ---- test_dsoc_top.sv ----
// self-checking bench for the distance output block
`timescale 1ns/100ps
module test_dsoc_top;
  import dsoc_pkg::*;
  logic clk_sys, resetn, reg_wr, reg_rd, raw_valid, link, conn, ask, hreq;
  logic sw1, sw2, send, srch;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, raw_dist, out_value;
  logic [24:0] ssi_word;
  logic [1:0] if_sel;
  logic [5:0] ser_cfg;
  logic [6:0] baddr;
  int error_cnt, n_checks, cyc, rx_cnt;
  dsoc_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .raw_dist(raw_dist), .raw_valid(raw_valid), .adapter_link_up(link),
    .adapter_connected(conn), .host_request(hreq), .first_switch_output(sw1),
    .second_switch_output(sw2), .out_value(out_value), .ssi_word(ssi_word),
    .serial_send(send), .searching(srch), .if_sel(if_sel), .serial_cfg(ser_cfg),
    .bus_addr(baddr));
  dsoc_host u_host (.clk_sys(clk_sys), .ask(ask), .serial_send(send),
    .host_request(hreq), .rx_cnt(rx_cnt));
  always #10 clk_sys = ~clk_sys;
  task automatic summarize;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard: whole run needs well under this
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic meas(input logic [31:0] d);
    @(posedge clk_sys);
    raw_dist <= d;
    raw_valid <= 1'b1;
    @(posedge clk_sys);
    raw_valid <= 1'b0;
    settle();
  endtask
  task automatic t_defaults;
    rd(OFS_HYST, 32'h5, "hyst");
    rd(OFS_ADDR, 32'h3, "addr");
    rd(OFS_OFFSET, 32'h0, "offset");
    rd(OFS_SERIAL, 32'h3, "serial");
    chk("if_sel", 32'h0, 32'(if_sel));
    chk("bus_addr", 32'h3, 32'(baddr));
    chk("serial_cfg", 32'h3, 32'(ser_cfg));
  endtask
  task automatic t_offset;
    wr(OFS_OFFSET, 32'hFFFF_FB50);
    meas(32'hBB8);
    chk("out", 32'h708, out_value);
    wr(OFS_OFFSET, 32'h186A1);
    rd(OFS_OFFSET, 32'hFFFF_FB50, "ofs_lim");
    wr(OFS_CMD, 32'h4);
    meas(32'hBB8);
    chk("out_teach", 32'h0, out_value);
    wr(OFS_CMD, 32'hC);
    meas(32'hBB8);
    chk("out_clr", 32'hBB8, out_value);
    wr(OFS_CTRL, 32'h1);
    meas(32'h9EC);
    chk("inch", 32'h2710, out_value);
    rd(OFS_VALUE, 32'h2710, "val_reg");
    wr(OFS_CTRL, 32'h0);
  endtask
  task automatic t_switch;
    logic [31:0] dv [9] = '{32'h384, 32'h3EC, 32'h3ED, 32'h3E4, 32'h3E2,
                            32'h7D0, 32'h762, 32'h7D0, 32'h83E};
    logic ev [9] = '{0, 0, 1, 1, 0, 1, 0, 1, 0};
    wr(OFS_HYST, 32'hA);
    wr(OFS_HYST, 32'hFF);
    rd(OFS_HYST, 32'hA, "hyst_lim");
    meas(32'h3E8);
    wr(OFS_CMD, 32'h1);
    rd(OFS_SP1, 32'h3E8, "sp1");
    for (int i = 0; i < 5; i++) begin
      meas(dv[i]);
      chk("sw1", 32'(ev[i]), 32'(sw1));
    end
    wr(OFS_CTRL, 32'h30);
    settle();
    chk("sw1_inv", 32'h1, 32'(sw1));
    meas(32'h7D0);
    wr(OFS_CMD, 32'h2);
    rd(OFS_SP2, 32'h7D0, "sp2");
    for (int i = 5; i < 9; i++) begin
      meas(dv[i]);
      chk("sw2", 32'(ev[i]), 32'(sw2));
    end
  endtask
  task automatic t_ssi;
    logic [31:0] cv [4] = '{32'h2, 32'h82, 32'h104, 32'h184};
    logic [31:0] xv [4] = '{32'h2710, 32'h2710, 32'h10E0, 32'h10E0};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, cv[i]);
      meas(32'h3E8);
      chk("ssi", xv[i], 32'(ssi_word));
    end
    wr(OFS_CTRL, 32'h82);
    meas(32'h1E_8480);
    chk("ssi25", 32'h0131_2D00, 32'(ssi_word));
    wr(OFS_CTRL, 32'h2);
    settle();
    chk("ssi24", 32'h0031_2D00, 32'(ssi_word));
    meas(32'h4D2);
    wr(OFS_CMD, 32'h1);
    rd(OFS_SP1, 32'h3E8, "sp1_ssi");
  endtask
  task automatic t_serial;
    int c;
    wr(OFS_CTRL, 32'h0);
    c = rx_cnt;
    meas(32'h3E8);
    meas(32'h3E9);
    chk("cont", 32'(c + 2), 32'(rx_cnt));
    wr(OFS_SERIAL, 32'h23);
    wr(OFS_SERIAL, 32'h25);
    rd(OFS_SERIAL, 32'h23, "ser_lim");
    c = rx_cnt;
    meas(32'h3E8);
    chk("no_req", 32'(c), 32'(rx_cnt));
    @(posedge clk_sys);
    ask <= 1'b1;
    @(posedge clk_sys);
    ask <= 1'b0;
    settle();
    chk("req", 32'(c + 1), 32'(rx_cnt));
    wr(OFS_CMD, 32'h20);
    settle();
    chk("cmd_send", 32'(c + 2), 32'(rx_cnt));
    wr(OFS_SERIAL, 32'h3);
    wr(OFS_ADDR, 32'h2);
    wr(OFS_ADDR, 32'h7D);
    rd(OFS_ADDR, 32'h3, "addr_lim");
    wr(OFS_ADDR, 32'h7C);
    rd(OFS_ADDR, 32'h7C, "addr_max");
  endtask
  task automatic t_search;
    wr(OFS_CTRL, 32'h6);
    settle();
    chk("search", 32'h1, 32'(srch));
    @(posedge clk_sys);
    conn <= 1'b0;
    wr(OFS_CMD, 32'h10);
    settle();
    chk("cancel", 32'h0, 32'(srch));
    wr(OFS_CTRL, 32'h6);
    settle();
    chk("no_restart", 32'h0, 32'(srch));
    @(posedge clk_sys);
    conn <= 1'b1;
    wr(OFS_CTRL, 32'h6);
    settle();
    chk("restart", 32'h1, 32'(srch));
    @(posedge clk_sys);
    link <= 1'b1;
    settle();
    chk("linked", 32'h0, 32'(srch));
  endtask
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    {reg_wr, reg_rd, raw_valid, link, ask} = '0;
    conn = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    raw_dist = 32'h0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_defaults();
    t_offset();
    t_switch();
    t_ssi();
    t_serial();
    t_search();
    summarize();
  end
endmodule
